// File: osc_pkg.sv
// Constants and carrier types for the octal switch serial control
package osc_pkg;

    localparam int            OSC_NUM_CH          = 8;
    localparam int            OSC_SYNC_STAGES     = 2;
    localparam logic [7:0]    OSC_CMD_RESET       = 8'hff;
    localparam logic [7:0]    OSC_SHIFT_RESET     = 8'h00;

    localparam int            OSC_CLK_PERIOD_NS   = 25;
    localparam int            OSC_SCLK_HALF_NS    = 175;
    localparam int            OSC_SCLK_HALF_CYC   = (OSC_SCLK_HALF_NS + OSC_CLK_PERIOD_NS - 1) / OSC_CLK_PERIOD_NS;
    localparam int            OSC_LAG_NS          = 250;
    localparam int            OSC_LAG_CYC         = (OSC_LAG_NS + OSC_CLK_PERIOD_NS - 1) / OSC_CLK_PERIOD_NS;

    localparam int            OSC_PIN_RESET_N     = 3;
    localparam int            OSC_PIN_CS_N        = 2;
    localparam int            OSC_PIN_SCLK        = 1;
    localparam int            OSC_PIN_SI          = 0;
    localparam logic [3:0]    OSC_PINS_IDLE       = 4'hc;

    typedef struct packed {
        logic reset_n;
        logic cs_n;
        logic sclk;
        logic si;
    } osc_pins_t;

    typedef enum logic [1:0] {
        OSC_ST_IDLE   = 2'b00,
        OSC_ST_SHIFT  = 2'b01,
        OSC_ST_COMMIT = 2'b11
    } osc_state_t;

endpackage : osc_pkg

// File: osc_sync.sv
// Two flip-flop level synchroniser for a bus of independent bits
`timescale 1ns/1ps
module osc_sync #(
    parameter int          WIDTH    = 1,
    parameter logic [63:0] RESET_VAL = 64'h0
) (
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1 || WIDTH > 64) begin
            $error("osc_sync: WIDTH out of range");
        end
    end

    // First stage feeds only the second stage
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            meta_q   <= RESET_VAL[WIDTH-1:0];
            sync_out <= RESET_VAL[WIDTH-1:0];
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : osc_sync

// File: osc_serial_ctrl.sv
// Serial control logic of an eight channel low side switch
// Operation
// - Eight output channels, each commanded by one bit of the serial word.
// - Serial data moves in either direction only while chip select is low.
// - Chip select rising copies the shift register into the output latch.
// - Chip select falling loads every output's drain status into the shift register.
// - Serial output driver is enabled when chip select goes low.
// - Deselected: serial clock and input ignored, serial output high impedance.
// - Serial input is sampled on each falling serial clock edge while selected.
// - Next status bit is driven out on each rising serial clock edge.
// - Command bit zero turns its switch on, one turns it off.
// - Full duplex: one bit in and one bit out per clock.
// - Held bits pass out as new bits enter, allowing daisy chains.
// - Each channel's switching and protection act independently of the others.
// - Words travel most significant bit first, first bit controls output seven.
// - Status reads one for an output off, zero for an output on.
// - Reset pin low clears the shift register and forces outputs off.
// - Latch disable low: a short latches only that output off; high: stays on.
`timescale 1ns/1ps
module osc_serial_ctrl
    import osc_pkg::*;
#(
    parameter int NUM_CH = OSC_NUM_CH
) (
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    input  wire logic              link_sclk_in,
    input  wire logic              cs_n_in,
    input  wire logic              si_in,
    input  wire logic              reset_n_in,
    input  wire logic              short_fault_latch_disable_in,
    input  wire logic [NUM_CH-1:0] drain_high_in,
    input  wire logic [NUM_CH-1:0] short_detect_in,
    output logic                   so_out,
    output logic                   so_oe_out,
    output logic      [NUM_CH-1:0] sw_on_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    initial begin
        if (NUM_CH < 2 || NUM_CH > OSC_NUM_CH) begin
            $error("osc_serial_ctrl: NUM_CH out of range");
        end
        // Edge detection must settle well inside one serial clock phase
        if (OSC_SYNC_STAGES + 2 > OSC_SCLK_HALF_CYC) begin
            $error("osc_serial_ctrl: system clock too slow for serial clock");
        end
        if (OSC_SYNC_STAGES + 2 > OSC_LAG_CYC) begin
            $error("osc_serial_ctrl: commit would not fit the lag time");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: command word captured on the serial clock itself

    logic [NUM_CH-1:0] link_shift_q;

    // Clock may toggle outside frames, so chip select gates the shift; no reset edge exists here
    always_ff @(negedge link_sclk_in) begin
        if (!cs_n_in) begin
            link_shift_q <= {link_shift_q[NUM_CH-2:0], si_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    osc_pins_t         pins_raw;
    osc_pins_t         pins_s;
    osc_pins_t         pins_prev_q;
    logic [NUM_CH-1:0] drain_s;
    logic [NUM_CH-1:0] short_s;
    logic              sfld_s;

    assign pins_raw = '{reset_n: reset_n_in, cs_n: cs_n_in, sclk: link_sclk_in, si: si_in};

    osc_sync #(.WIDTH(4), .RESET_VAL({60'h0, OSC_PINS_IDLE})) u_sync_pins (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    osc_sync #(.WIDTH(2 * NUM_CH + 1), .RESET_VAL(64'h0)) u_sync_chan (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .async_in ({short_fault_latch_disable_in, short_detect_in, drain_high_in}),
        .sync_out ({sfld_s, short_s, drain_s})
    );

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pins_prev_q <= OSC_PINS_IDLE;
        end else begin
            pins_prev_q <= pins_s;
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic pin_reset;

    assign cs_fall   = pins_prev_q.cs_n & ~pins_s.cs_n;
    assign cs_rise   = ~pins_prev_q.cs_n & pins_s.cs_n;
    // Serial clock edges count only while selected
    assign sclk_rise = ~pins_prev_q.sclk & pins_s.sclk & ~pins_s.cs_n;
    assign sclk_fall = pins_prev_q.sclk & ~pins_s.sclk & ~pins_s.cs_n;
    assign pin_reset = ~pins_s.reset_n;

    ////////////////////////////////////////////////////////////////////////////
    // Frame state

    osc_state_t state_q;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_q <= OSC_ST_IDLE;
        end else begin
            case (state_q)
                OSC_ST_IDLE: begin
                    if (cs_fall) begin
                        state_q <= OSC_ST_SHIFT;
                    end
                end
                OSC_ST_SHIFT: begin
                    if (cs_rise) begin
                        state_q <= OSC_ST_COMMIT;
                    end
                end
                default: begin
                    state_q <= OSC_ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status shift register and serial output

    logic [NUM_CH-1:0] sr_q;
    logic              so_q;
    logic              so_oe_q;

    always_ff @(posedge clock_in) begin
        if (rst_in || pin_reset) begin
            sr_q <= OSC_SHIFT_RESET[NUM_CH-1:0];
        end else if (cs_fall) begin
            sr_q <= drain_s;
        end else if (sclk_fall) begin
            // Held bits move toward the output as new ones enter
            sr_q <= {sr_q[NUM_CH-2:0], pins_s.si};
        end
    end

    // Serial output ignores the reset pin
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            so_q <= 1'b0;
        end else if (cs_fall) begin
            so_q <= drain_s[NUM_CH-1];
        end else if (sclk_rise) begin
            so_q <= sr_q[NUM_CH-1];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            so_oe_q <= 1'b0;
        end else if (cs_fall) begin
            so_oe_q <= 1'b1;
        end else if (cs_rise) begin
            so_oe_q <= 1'b0;
        end
    end

    assign so_out    = so_q;
    assign so_oe_out = so_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // Command latch, per channel protection and drive

    logic [NUM_CH-1:0] cmd_q;
    logic [NUM_CH-1:0] fault_q;
    logic [NUM_CH-1:0] on_q;
    logic              commit;

    // Link word has been still for the lag time, so a direct read is safe
    assign commit = (state_q == OSC_ST_COMMIT);

    always_ff @(posedge clock_in) begin
        if (rst_in || pin_reset) begin
            cmd_q <= OSC_CMD_RESET[NUM_CH-1:0];
        end else if (commit) begin
            cmd_q <= link_shift_q;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
            always_ff @(posedge clock_in) begin
                if (rst_in || pin_reset) begin
                    fault_q[ch] <= 1'b0;
                end else if (short_s[ch] && on_q[ch] && !sfld_s) begin
                    fault_q[ch] <= 1'b1;
                end else if (commit) begin
                    // A fresh command retries a latched off channel
                    fault_q[ch] <= 1'b0;
                end
            end

            always_ff @(posedge clock_in) begin
                if (rst_in || pin_reset) begin
                    on_q[ch] <= 1'b0;
                end else begin
                    on_q[ch] <= ~cmd_q[ch] & ~fault_q[ch];
                end
            end
        end
    endgenerate

    assign sw_on_out = on_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence seq_deselect;
        cs_rise && !pin_reset ##1 commit;
    endsequence

    sequence seq_select;
        cs_fall && !pin_reset;
    endsequence

    chk_oe_on_select: assert property (@(posedge clock_in) disable iff (rst_in)
        cs_fall |=> so_oe_out && so_out == $past(drain_s[NUM_CH-1]))
        else $error("serial output not enabled on select");

    chk_oe_off_deselect: assert property (@(posedge clock_in) disable iff (rst_in)
        cs_rise |=> !so_oe_out [*2])
        else $error("serial output still driven after deselect");

    chk_status_load: assert property (@(posedge clock_in) disable iff (rst_in)
        seq_select |=> sr_q == $past(drain_s))
        else $error("drain status not loaded on select");

    chk_latch_commit: assert property (@(posedge clock_in) disable iff (rst_in)
        seq_deselect ##0 !pin_reset |=> cmd_q == $past(link_shift_q) ##1 (sw_on_out & cmd_q) == '0)
        else $error("command not latched on deselect");

    chk_inverted_sense: assert property (@(posedge clock_in) disable iff (rst_in)
        !pin_reset |=> sw_on_out == $past(~cmd_q & ~fault_q))
        else $error("switch drive does not follow inverted command");

    chk_reset_off: assert property (@(posedge clock_in) disable iff (rst_in)
        pin_reset |=> sw_on_out == '0 && sr_q == '0 && $stable(so_out))
        else $error("reset pin did not force outputs off");

    chk_so_shift: assert property (@(posedge clock_in) disable iff (rst_in)
        sclk_rise |=> so_out == $past(sr_q[NUM_CH-1]))
        else $error("serial output did not shift on rising clock");

    chk_si_sample: assert property (@(posedge clock_in) disable iff (rst_in)
        sclk_fall && !pin_reset |=> sr_q == $past({sr_q[NUM_CH-2:0], pins_s.si}))
        else $error("serial input not sampled on falling clock");

    chk_idle_ignore: assert property (@(posedge clock_in) disable iff (rst_in)
        pins_s.cs_n && pins_prev_q.cs_n && !pin_reset |=> $stable(sr_q) && $stable(so_out))
        else $error("shift register moved while deselected");

    chk_fault_latch: assert property (@(posedge clock_in) disable iff (rst_in)
        (short_s & on_q & {NUM_CH{!sfld_s}}) != '0 && !pin_reset
        |=> ##1 (sw_on_out & $past(short_s & on_q, 2)) == '0)
        else $error("shorted channel not latched off");

    // Protection latching and enable holding
    chk_limit_no_latch: assert property (@(posedge clock_in) disable iff (rst_in)
        sfld_s && !pin_reset |=> (fault_q & ~$past(fault_q)) == '0)
        else $error("fault latched while latch disable high");

    chk_fault_only_short: assert property (@(posedge clock_in) disable iff (rst_in)
        !pin_reset |=> (fault_q & ~$past(fault_q) & ~$past(short_s)) == '0)
        else $error("fault latched for a channel without a short");

    chk_fault_retry: assert property (@(posedge clock_in) disable iff (rst_in)
        commit && (short_s & on_q & {NUM_CH{!sfld_s}}) == '0 |=> fault_q == '0)
        else $error("latched fault not cleared by new command");

    chk_oe_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        so_oe_out && !cs_rise |=> so_oe_out)
        else $error("serial output released while selected");

    chk_reset_keeps_oe: assert property (@(posedge clock_in) disable iff (rst_in)
        pin_reset && !cs_fall && !cs_rise |=> $stable(so_oe_out))
        else $error("reset pin changed serial output enable");

endmodule : osc_serial_ctrl

// File: osc_host_model.sv
// Host side serial master model for the octal switch serial control
`timescale 1ns/1ps
module osc_host_model (
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      si_out,
    input  wire logic so_in,
    input  wire logic so_oe_in
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        si_out   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Full duplex frame of n bits, clock low at both select edges
    task automatic frame(input logic [15:0] tx, input int n, input int half_ns,
                         output logic [15:0] rx, output logic oe_ok);
        rx       = 16'h0000;
        oe_ok    = 1'b1;
        cs_n_out = 1'b0;
        #(half_ns);
        for (int i = n - 1; i >= 0; i--) begin
            si_out   = tx[i];
            sclk_out = 1'b1;
            #(half_ns);
            rx[i]    = so_in;
            oe_ok    = oe_ok & so_oe_in;
            sclk_out = 1'b0;
            #(half_ns);
        end
        cs_n_out = 1'b1;
        si_out   = ~si_out;
    endtask : frame

    ////////////////////////////////////////////////////////////////////////////
    // Deselected clock and data activity, allowed but not recommended
    task automatic idle_noise(input int n);
        for (int i = 0; i < n; i++) begin
            si_out   = ~si_out;
            sclk_out = 1'b1;
            #200;
            sclk_out = 1'b0;
            #200;
        end
    endtask : idle_noise
endmodule : osc_host_model

// File: osc_serial_ctrl_test.sv
// Self-checking bench for the octal switch serial control
`timescale 1ns/1ps
module osc_serial_ctrl_test;
    import osc_pkg::*;
    logic        clock_in;
    logic        rst_in;
    logic        sclk;
    logic        cs_n;
    logic        si;
    logic        reset_n_in;
    logic        sfl_dis;
    logic [7:0]  drain;
    logic [7:0]  short_det;
    logic [7:0]  sw_on;
    logic [7:0]  cmd;
    logic        so;
    logic        so_oe;
    logic        so_line;
    logic        oe_ok;
    logic [15:0] rx;
    int          err_total;
    int          comparisons;

    // Undriven line must not look like valid data
    assign so_line = so_oe ? so : ~so;

    osc_serial_ctrl u_osc_serial_ctrl (
        .clock_in(clock_in), .rst_in(rst_in), .link_sclk_in(sclk), .cs_n_in(cs_n), .si_in(si),
        .reset_n_in(reset_n_in), .short_fault_latch_disable_in(sfl_dis), .drain_high_in(drain),
        .short_detect_in(short_det), .so_out(so), .so_oe_out(so_oe), .sw_on_out(sw_on));
    osc_host_model u_osc_host_model (
        .cs_n_out(cs_n), .sclk_out(sclk), .si_out(si), .so_in(so_line), .so_oe_in(so_oe));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] exp_sw(input logic [7:0] c, input logic [7:0] f);
        return {8'h00, ~c & ~f};
    endfunction : exp_sw

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic settle;
        repeat (10) @(negedge clock_in);
    endtask : settle

    task automatic tally_and_finish;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    initial begin
        #1000000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        err_total   = 0;
        comparisons = 0;
        rst_in      = 1'b1;
        reset_n_in  = 1'b1;
        sfl_dis     = 1'b0;
        drain       = 8'hff;
        short_det   = 8'h00;
        void'($urandom(79232));
        repeat (5) @(negedge clock_in);
        rst_in = 1'b0;
        check("sw_on_rst", {8'h00, sw_on}, 16'h0000);
        check("so_oe_rst", {15'h0000, so_oe}, 16'h0000);
        repeat (4) @(negedge clock_in);
        $display("test reset done");
        for (int k = 0; k < 6; k++) begin
            cmd     = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
            drain   = 8'($urandom);
            sfl_dis = 1'($urandom);
            u_osc_host_model.frame({8'h00, cmd}, 8, (k % 2) ? 400 : 250, rx, oe_ok);
            check("status", rx, {8'h00, drain});
            check("so_oe_sel", {15'h0000, oe_ok}, 16'h0001);
            settle();
            check("sw_on", {8'h00, sw_on}, exp_sw(cmd, 8'h00));
            check("so_oe_desel", {15'h0000, so_oe}, 16'h0000);
        end
        $display("test random frames done");
        u_osc_host_model.idle_noise(8);
        settle();
        check("sw_on_noise", {8'h00, sw_on}, exp_sw(cmd, 8'h00));
        $display("test deselected noise done");
        cmd = 8'($urandom);
        u_osc_host_model.frame({cmd ^ 8'h5a, cmd}, 16, 250, rx, oe_ok);
        check("chain", rx, {drain, cmd ^ 8'h5a});
        settle();
        check("sw_on_chain", {8'h00, sw_on}, exp_sw(cmd, 8'h00));
        $display("test daisy chain done");
        sfl_dis = 1'b0;
        u_osc_host_model.frame(16'h0000, 8, 250, rx, oe_ok);
        settle();
        short_det = 8'h08;
        settle();
        check("fault_latch", {8'h00, sw_on}, exp_sw(8'h00, 8'h08));
        short_det = 8'h00;
        settle();
        check("fault_held", {8'h00, sw_on}, exp_sw(8'h00, 8'h08));
        sfl_dis   = 1'b1;
        short_det = 8'h08;
        u_osc_host_model.frame(16'h0000, 8, 250, rx, oe_ok);
        settle();
        check("fault_limit", {8'h00, sw_on}, exp_sw(8'h00, 8'h00));
        $display("test short fault done");
        short_det  = 8'h00;
        reset_n_in = 1'b0;
        repeat (12) @(negedge clock_in);
        check("sw_on_pin_rst", {8'h00, sw_on}, 16'h0000);
        reset_n_in = 1'b1;
        settle();
        check("sw_on_after_rst", {8'h00, sw_on}, exp_sw(OSC_CMD_RESET, 8'h00));
        $display("test reset pin done");
        tally_and_finish();
    end
endmodule : osc_serial_ctrl_test
